// ===== include/debug_err_defines.svh
/*
 Constants of the debug command error and status flag logic.
 Assumes inclusion by bare name from files that need the figures.
*/
`ifndef DEBUG_ERR_DEFINES_SVH
`define DEBUG_ERR_DEFINES_SVH

`define STATUS_OVERRUN_BIT     4
`define STATUS_NO_RESPONSE_BIT 3
`define STATUS_READ_INV_BIT    2
`define STATUS_ILLEGAL_BIT     1
`define STATUS_RESET           8'h00
`define FAILED_DATA_BYTE       8'hee
`define FREE_CYCLE_TIMEOUT     10'h200
`define ACK_DELAY_CYCLES       5'h10
`define ACK_PULSE_CYCLES       5'h10

`endif

// ===== include/debug_err_pkg.sv
/*
 Types of the debug command error and status flag logic.
 Assumes no other package.
*/
package debug_err_pkg;

	typedef struct packed {
		logic start;
		logic is_write;
		logic is_mem;
		logic is_pc_sample;
		logic is_cpu_reg;
		logic is_halt_req;
		logic is_sync;
	} cmd_s;

	typedef struct packed {
		logic       addr_implemented;
		logic       targets_flash;
		logic       crn_valid;
	} target_s;

	typedef struct packed {
		logic       bus_free;
		logic       done;
		logic       ecc_error;
		logic       abort_allowed;
		logic [7:0] read_data;
	} access_rsp_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_ABORT_WAIT
	} cmd_state_e;

endpackage

// ===== design/free_cycle_watchdog.sv
/*
 Counts core clocks spent waiting for a free bus cycle and flags the timeout.
 Assumes run stays high for the whole wait and drops when the access ends.
*/
`timescale 1ns/1ps
`default_nettype none
`include "debug_err_defines.svh"

module free_cycle_watchdog (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic run,
	input  wire logic bus_free,
	output logic      expired
);

	logic [9:0] count_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= 10'h000;
		end else if (!run || bus_free) begin
			count_reg <= 10'h000;
		end else if (count_reg != `FREE_CYCLE_TIMEOUT) begin
			count_reg <= count_reg + 10'h001;
		end
	end

	// one pulse on reaching the limit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			expired <= 1'b0;
		end else begin
			expired <= run && !bus_free && (count_reg == `FREE_CYCLE_TIMEOUT - 10'h001);
		end
	end

endmodule
`default_nettype wire

// ===== design/debug_command_error_flags.sv
/*
 Error and status flag logic of the single-wire background debug controller.
 Assumes a serial engine that decodes host commands into one-cycle pulses
 and a bus port that performs the internal accesses; all inputs are
 synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "debug_err_defines.svh"

module debug_command_error_flags (
	input  wire logic                       clk,
	input  wire logic                       arst_n,
	input  wire logic                       debug_pin_in,
	output logic                            debug_pin_out,
	output logic                            debug_pin_oe,
	input  wire debug_err_pkg::cmd_s        cmd,
	input  wire debug_err_pkg::target_s     target,
	input  wire logic                       data_fetch_start,
	input  wire logic                       status_wr,
	input  wire logic [7:0]                 status_wr_data,
	input  wire logic                       handshake_enable,
	input  wire logic                       cycle_take_enable,
	input  wire logic                       stop_clock_keep,
	input  wire logic                       stop_mode,
	input  wire logic                       wait_mode,
	input  wire logic                       wait_return_pending,
	input  wire logic                       external_wait,
	input  wire debug_err_pkg::access_rsp_s rsp,
	output logic                            access_req,
	output logic                            access_abort,
	output logic                            halt_req,
	output logic                            cmd_busy,
	output logic [7:0]                      data_out,
	output logic [7:0]                      debug_status_low
);

	debug_err_pkg::cmd_state_e state_reg;
	debug_err_pkg::cmd_state_e state_next;
	logic       overrun_flag;
	logic       no_response_flag;
	logic       read_invalid_flag;
	logic       illegal_access_flag;
	logic       cur_illegal_reg;
	logic       cur_is_write_reg;
	logic       halt_pending_reg;
	logic       ack_pending_reg;
	logic       ack_drive_reg;
	logic [4:0] ack_cnt_reg;
	logic       timeout;
	logic       illegal_now;
	logic       stop_fail;
	logic       wait_fail;
	logic       fetch_fail;
	logic       write_fail;
	logic       host_collision;
	logic       set_overrun;
	logic       set_no_response;
	logic       start_ok;
	logic       abort_now;
	logic       wants_access;

	// decoded once, used for the flag and the byte substitution
	function automatic logic is_illegal(debug_err_pkg::cmd_s c, debug_err_pkg::target_s t);
		is_illegal = (c.is_mem && !t.addr_implemented) ||
			(c.is_mem && c.is_write && t.targets_flash) ||
			(c.is_cpu_reg && !t.crn_valid);
	endfunction

	function automatic logic clear_bit(logic [7:0] d, int pos, logic wr);
		clear_bit = wr && d[pos];
	endfunction

	free_cycle_watchdog u_watchdog (
		.clk      (clk),
		.arst_n   (arst_n),
		// timer only counts in handshake mode without cycle taking
		.run      ((state_reg == debug_err_pkg::ST_ACCESS) && handshake_enable &&
			!cycle_take_enable),
		.bus_free (rsp.bus_free),
		.expired  (timeout)
	);

	always_comb begin
		wants_access = cmd.is_mem || cmd.is_pc_sample || cmd.is_cpu_reg;
		illegal_now = is_illegal(cmd, target);
		stop_fail = stop_mode && !stop_clock_keep && (cmd.is_mem || cmd.is_pc_sample);
		wait_fail = wait_return_pending || (wait_mode && (cmd.is_halt_req || cmd.is_cpu_reg));
		// access still running when host fetches
		fetch_fail = (!handshake_enable || cycle_take_enable) && data_fetch_start &&
			(state_reg == debug_err_pkg::ST_ACCESS);
		// write still running when next command starts
		write_fail = (!handshake_enable || cycle_take_enable) && cmd.start && cur_is_write_reg &&
			(state_reg == debug_err_pkg::ST_ACCESS);
		// host drives low over a pending handshake pulse
		host_collision = handshake_enable && ack_pending_reg && !ack_drive_reg && !debug_pin_in;
		set_overrun = host_collision || (cmd.start && !cmd.is_sync &&
			(state_reg != debug_err_pkg::ST_IDLE));
		set_no_response = timeout || fetch_fail || write_fail ||
			(cmd.start && (stop_fail || wait_fail));
		start_ok = cmd.start && (state_reg == debug_err_pkg::ST_IDLE) && wants_access &&
			!overrun_flag && !illegal_now && !stop_fail && !wait_fail;
		abort_now = (state_reg == debug_err_pkg::ST_ACCESS) && (timeout || fetch_fail || write_fail);
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			debug_err_pkg::ST_IDLE: begin
				if (start_ok) begin
					state_next = debug_err_pkg::ST_ACCESS;
				end
			end
			debug_err_pkg::ST_ACCESS: begin
				if (rsp.done) begin
					state_next = debug_err_pkg::ST_IDLE;
				end else if (abort_now) begin
					state_next = debug_err_pkg::ST_ABORT_WAIT;
				end
			end
			debug_err_pkg::ST_ABORT_WAIT: begin
				// held by external wait until released
				if (rsp.done || (rsp.abort_allowed && !external_wait)) begin
					state_next = debug_err_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = debug_err_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= debug_err_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// flags: a set in the same cycle as a clear wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overrun_flag        <= 1'b0;
			no_response_flag    <= 1'b0;
			read_invalid_flag   <= 1'b0;
			illegal_access_flag <= 1'b0;
		end else begin
			overrun_flag <= set_overrun || (overrun_flag && !(cmd.start && cmd.is_sync));
			no_response_flag <= set_no_response || (no_response_flag &&
				!clear_bit(status_wr_data, `STATUS_NO_RESPONSE_BIT, status_wr));
			// ecc error on a debug read
			read_invalid_flag <= (rsp.done && rsp.ecc_error && !cur_is_write_reg &&
				(state_reg != debug_err_pkg::ST_IDLE)) || (read_invalid_flag &&
				!clear_bit(status_wr_data, `STATUS_READ_INV_BIT, status_wr));
			illegal_access_flag <= (cmd.start && (state_reg == debug_err_pkg::ST_IDLE) &&
				!overrun_flag && illegal_now) || (illegal_access_flag &&
				!clear_bit(status_wr_data, `STATUS_ILLEGAL_BIT, status_wr));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_illegal_reg  <= 1'b0;
			cur_is_write_reg <= 1'b0;
		end else if (cmd.start && (state_reg == debug_err_pkg::ST_IDLE)) begin
			cur_illegal_reg  <= illegal_now;
			cur_is_write_reg <= cmd.is_write;
		end
	end

	// halt kept through wait mode, issued once it ends
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			halt_pending_reg <= 1'b0;
			halt_req         <= 1'b0;
		end else begin
			halt_pending_reg <= (halt_pending_reg || (cmd.start && cmd.is_halt_req &&
				!overrun_flag)) && wait_mode;
			halt_req <= !wait_mode && (halt_pending_reg || (cmd.start && cmd.is_halt_req &&
				!overrun_flag && !wait_return_pending));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			access_req   <= 1'b0;
			access_abort <= 1'b0;
			cmd_busy     <= 1'b0;
		end else begin
			access_req   <= (state_next == debug_err_pkg::ST_ACCESS);
			// abort only where permitted and no external wait
			access_abort <= (state_next == debug_err_pkg::ST_ABORT_WAIT) ? 1'b0 :
				((state_reg != debug_err_pkg::ST_IDLE) && !rsp.done &&
				(abort_now || state_reg == debug_err_pkg::ST_ABORT_WAIT));
			cmd_busy     <= (state_next != debug_err_pkg::ST_IDLE);
		end
	end

	// returned byte for the current access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= 8'h00;
		end else if (cmd.start && (state_reg == debug_err_pkg::ST_IDLE) && illegal_now) begin
			// illegal access reads back fixed byte
			data_out <= `FAILED_DATA_BYTE;
		end else if (set_no_response || no_response_flag || cur_illegal_reg) begin
			// failed access reads back fixed byte
			data_out <= `FAILED_DATA_BYTE;
		end else if (rsp.done && (state_reg != debug_err_pkg::ST_IDLE)) begin
			// real data even on ecc error
			data_out <= rsp.read_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			debug_status_low <= `STATUS_RESET;
		end else begin
			debug_status_low <= `STATUS_RESET;
			debug_status_low[`STATUS_OVERRUN_BIT]     <= overrun_flag;
			debug_status_low[`STATUS_NO_RESPONSE_BIT] <= no_response_flag;
			debug_status_low[`STATUS_READ_INV_BIT]    <= read_invalid_flag;
			debug_status_low[`STATUS_ILLEGAL_BIT]     <= illegal_access_flag;
		end
	end

	// handshake pulse: delay, then drive the pin low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_pending_reg <= 1'b0;
			ack_drive_reg   <= 1'b0;
			ack_cnt_reg     <= 5'h00;
		end else if (host_collision) begin
			// pulse dropped: the host already owns the line
			ack_pending_reg <= 1'b0;
			ack_cnt_reg     <= 5'h00;
		end else if (ack_drive_reg) begin
			ack_cnt_reg <= ack_cnt_reg + 5'h01;
			if (ack_cnt_reg == `ACK_PULSE_CYCLES - 5'h01) begin
				ack_drive_reg   <= 1'b0;
				ack_pending_reg <= 1'b0;
				ack_cnt_reg     <= 5'h00;
			end
		end else if (ack_pending_reg) begin
			ack_cnt_reg <= ack_cnt_reg + 5'h01;
			if (ack_cnt_reg == `ACK_DELAY_CYCLES - 5'h01) begin
				ack_drive_reg <= 1'b1;
				ack_cnt_reg   <= 5'h00;
			end
		end else if (handshake_enable && (state_reg != debug_err_pkg::ST_IDLE) &&
			(state_next == debug_err_pkg::ST_IDLE)) begin
			ack_pending_reg <= 1'b1;
		end
	end

	// open-drain style: only ever pulls low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			debug_pin_out <= 1'b0;
			debug_pin_oe  <= 1'b0;
		end else begin
			debug_pin_out <= 1'b0;
			debug_pin_oe  <= ack_drive_reg && !host_collision;
		end
	end

endmodule
`default_nettype wire

// ===== dv/debug_command_error_flags_checker.sv
/*
 Assertion checker for the debug error flag block.
 Assumes a bind to the block's top module, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_command_error_flags_checker (
	input wire logic                       clk,
	input wire logic                       arst_n,
	input wire logic                       debug_pin_out,
	input wire logic                       debug_pin_oe,
	input wire debug_err_pkg::cmd_s        cmd,
	input wire debug_err_pkg::target_s     target,
	input wire logic                       status_wr,
	input wire logic [7:0]                 status_wr_data,
	input wire logic                       handshake_enable,
	input wire logic                       cycle_take_enable,
	input wire logic                       stop_mode,
	input wire logic                       stop_clock_keep,
	input wire logic                       external_wait,
	input wire debug_err_pkg::access_rsp_s rsp,
	input wire logic                       access_req,
	input wire logic                       access_abort,
	input wire logic                       cmd_busy,
	input wire logic [7:0]                 data_out,
	input wire logic [7:0]                 debug_status_low
);
	logic [9:0] stall_cnt_reg;

	// clears to zero once flagged, so a missing flag shows as a runaway count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			stall_cnt_reg <= 10'h000;
		else if (access_req && !rsp.bus_free && handshake_enable && !cycle_take_enable
			&& !debug_status_low[3])
			stall_cnt_reg <= stall_cnt_reg + 10'h001;
		else
			stall_cnt_reg <= 10'h000;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_pin_low; debug_pin_oe |-> !debug_pin_out; endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin driven high");
	property p_overrun; cmd.start && cmd_busy && !cmd.is_sync |-> ##2 debug_status_low[4];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not set");
	property p_blocked; cmd.start && !cmd.is_sync && !cmd_busy && debug_status_low[4]
		&& !$past(cmd.start) |=> !access_req; endproperty
	a_blocked: assert property (p_blocked) else $error("access after overrun");
	property p_stall; stall_cnt_reg <= 10'h204; endproperty
	a_stall: assert property (p_stall) else $error("no-response late");
	property p_abort; access_abort |-> $past(rsp.abort_allowed) && !$past(external_wait);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not allowed");
	property p_stop; cmd.start && cmd.is_mem && stop_mode && !stop_clock_keep && !cmd_busy
		|=> !access_req ##1 debug_status_low[3]; endproperty
	a_stop: assert property (p_stop) else $error("stop access not refused");
	property p_fail_data; rsp.done && cmd_busy && debug_status_low[3] |=> data_out == 8'hee;
	endproperty
	a_fail_data: assert property (p_fail_data) else $error("failed byte wrong");
	property p_ecc; rsp.done && rsp.ecc_error && access_req && !debug_status_low[3]
		|=> data_out == $past(rsp.read_data) ##1 debug_status_low[2]; endproperty
	a_ecc: assert property (p_ecc) else $error("ecc read wrong");
	property p_illegal; cmd.start && cmd.is_mem && !target.addr_implemented && !cmd_busy
		&& !debug_status_low[4] && !stop_mode |=> data_out == 8'hee ##1 debug_status_low[1];
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal access wrong");
	property p_clear; status_wr && status_wr_data[3] && !access_req && !cmd.start
		|-> ##2 !debug_status_low[3]; endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule
`default_nettype wire

// ===== dv/debug_host_model.sv
/*
 External debug host on the single debug pin.
 Assumes a pull-up on the pin; the bench orders any pull-low.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
	input  wire logic pull_low,
	input  wire logic debug_pin_oe,
	input  wire logic debug_pin_out,
	output logic      debug_pin_in
);
	assign debug_pin_in = ((debug_pin_oe && !debug_pin_out) || pull_low) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== dv/debug_command_error_flags_tb_top.sv
/*
 Self-checking bench of the debug error flag block.
 Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_command_error_flags_tb_top;
	logic                       clk, arst_n, debug_pin_in, pull_low, data_fetch_start;
	logic                       status_wr, handshake_enable, cycle_take_enable, stop_mode;
	logic                       stop_clock_keep, wait_mode, wait_return_pending, seen;
	logic                       external_wait, debug_pin_out, debug_pin_oe, access_req;
	logic                       access_abort, halt_req, cmd_busy;
	logic [7:0]                 status_wr_data, data_out, debug_status_low;
	debug_err_pkg::cmd_s        cmd;
	debug_err_pkg::target_s     target;
	debug_err_pkg::access_rsp_s rsp;
	int                         n_mismatch, check_count, n;
	logic [6:0]                 ic [3] = '{7'h50, 7'h70, 7'h44};
	logic [2:0]                 it [3] = '{3'h1, 3'h7, 3'h4};

	debug_host_model i_debug_host_model (.pull_low, .debug_pin_oe, .debug_pin_out,
		.debug_pin_in);
	debug_command_error_flags i_debug_command_error_flags (.clk, .arst_n, .debug_pin_in,
		.debug_pin_out, .debug_pin_oe, .cmd, .target, .data_fetch_start, .status_wr,
		.status_wr_data, .handshake_enable, .cycle_take_enable, .stop_clock_keep, .stop_mode,
		.wait_mode, .wait_return_pending, .external_wait, .rsp, .access_req, .access_abort,
		.halt_req, .cmd_busy, .data_out, .debug_status_low);

	task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic go(input logic [6:0] c, input logic [2:0] t);
		@(posedge clk);
		cmd <= c;
		target <= t;
		@(posedge clk);
		cmd <= 7'h00;
	endtask
	task automatic done(input logic [7:0] d, input logic e);
		@(posedge clk);
		rsp.done <= 1'b1;
		rsp.ecc_error <= e;
		rsp.read_data <= d;
		@(posedge clk);
		rsp.done <= 1'b0;
		settle(2);
	endtask
	task automatic rd(input logic [7:0] d, input logic e);
		go(7'h50, 3'h5);
		done(d, e);
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		status_wr <= 1'b1;
		status_wr_data <= d;
		@(posedge clk);
		status_wr <= 1'b0;
		settle(2);
	endtask
	task automatic wrap_up();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// the whole sequence needs about 830 cycles
	initial begin
		#20000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		{arst_n, pull_low, data_fetch_start, status_wr, status_wr_data} = '0;
		{handshake_enable, cycle_take_enable, stop_clock_keep, stop_mode} = '0;
		{wait_mode, wait_return_pending, external_wait} = '0;
		{n_mismatch, check_count} = '0;
		cmd = '0;
		target = '0;
		rsp = 12'h900;
		settle(2);
		arst_n <= 1'b1;
		settle(1);
		cmp("status after reset", 8'h00, debug_status_low);
		rd(8'h5a, 1'b0);
		cmp("read data", 8'h5a, data_out);
		rd(8'ha5, 1'b1);
		cmp("ecc read data", 8'ha5, data_out);
		cmp("ecc status", 8'h04, debug_status_low);
		wr(8'h00);
		cmp("zero write keeps", 8'h04, debug_status_low);
		wr(8'h04);
		cmp("one write clears", 8'h00, debug_status_low);
		for (int i = 0; i < 3; i++) begin
			go(ic[i], it[i]);
			settle(2);
			cmp("illegal data", 8'hee, data_out);
			cmp("illegal status", 8'h02, debug_status_low);
			wr(8'h02);
		end
		go(7'h50, 3'h5);
		go(7'h50, 3'h5);
		done(8'h11, 1'b0);
		cmp("overrun status", 8'h10, debug_status_low);
		go(7'h50, 3'h5);
		settle(2);
		cmp("blocked access", 8'h00, {7'h00, access_req});
		wr(8'h10);
		cmp("overrun kept", 8'h10, debug_status_low);
		go(7'h41, 3'h0);
		settle(2);
		cmp("sync clears", 8'h00, debug_status_low);
		stop_mode <= 1'b1;
		go(7'h50, 3'h5);
		settle(2);
		cmp("stop status", 8'h08, debug_status_low);
		wr(8'h08);
		stop_clock_keep <= 1'b1;
		rd(8'h3c, 1'b0);
		cmp("stop kept clock", 8'h3c, data_out);
		{stop_mode, stop_clock_keep} <= 2'h0;
		wait_return_pending <= 1'b1;
		go(7'h44, 3'h5);
		settle(2);
		cmp("wait return status", 8'h08, debug_status_low);
		wait_return_pending <= 1'b0;
		wr(8'h08);
		wait_mode <= 1'b1;
		go(7'h42, 3'h5);
		settle(2);
		cmp("halt in wait", 8'h08, debug_status_low);
		cmp("halt held", 8'h00, {7'h00, halt_req});
		wr(8'h08);
		wait_mode <= 1'b0;
		for (n = 0; n < 8 && halt_req !== 1'b1; n++) settle(1);
		cmp("halt after wait", 8'h01, {7'h00, halt_req});
		{cycle_take_enable, rsp.abort_allowed} <= 2'h2;
		go(7'h50, 3'h5);
		@(posedge clk) data_fetch_start <= 1'b1;
		@(posedge clk) data_fetch_start <= 1'b0;
		settle(2);
		cmp("early fetch", 8'h08, debug_status_low);
		done(8'h77, 1'b0);
		cmp("failed byte", 8'hee, data_out);
		wr(8'h08);
		// write still running when the next command arrives
		go(7'h70, 3'h4);
		go(7'h41, 3'h0);
		settle(2);
		cmp("write then command", 8'h08, debug_status_low);
		done(8'h00, 1'b0);
		cmp("write failed byte", 8'hee, data_out);
		wr(8'h08);
		{cycle_take_enable, rsp.abort_allowed, handshake_enable} <= 3'h3;
		{rsp.bus_free, external_wait} <= 2'h1;
		go(7'h50, 3'h5);
		for (n = 0; n < 600 && debug_status_low[3] !== 1'b1; n++) settle(1);
		cmp("stall span", 8'h01, {7'h00, n >= 510 && n <= 520});
		seen = 1'b0;
		repeat (20) begin
			settle(1);
			seen |= access_abort;
		end
		cmp("abort under wait", 8'h00, {7'h00, seen});
		cmp("busy under wait", 8'h01, {7'h00, cmd_busy});
		external_wait <= 1'b0;
		for (n = 0; n < 8 && access_abort !== 1'b1; n++) settle(1);
		cmp("abort after wait", 8'h01, {7'h00, access_abort});
		rsp.bus_free <= 1'b1;
		settle(40);
		wr(8'h08);
		rd(8'h22, 1'b0);
		for (n = 0; n < 40 && debug_pin_oe !== 1'b1; n++) settle(1);
		cmp("pin pulled low", 8'h00, {7'h00, debug_pin_in});
		settle(40);
		rd(8'h33, 1'b0);
		@(posedge clk) pull_low <= 1'b1;
		@(posedge clk) pull_low <= 1'b0;
		settle(3);
		cmp("collision overrun", 8'h10, debug_status_low);
		settle(40);
		go(7'h41, 3'h0);
		settle(2);
		cmp("sync after collision", 8'h00, debug_status_low);
		// reset in mid-run with a flag standing
		go(7'h50, 3'h1);
		settle(2);
		cmp("illegal before reset", 8'h02, debug_status_low);
		@(posedge clk) arst_n <= 1'b0;
		@(posedge clk) arst_n <= 1'b1;
		settle(1);
		cmp("status after mid reset", 8'h00, debug_status_low);
		cmp("data after mid reset", 8'h00, data_out);
		wrap_up();
	end
endmodule

bind debug_command_error_flags debug_command_error_flags_checker i_chk (.clk, .arst_n,
	.debug_pin_out, .debug_pin_oe, .cmd, .target, .status_wr, .status_wr_data,
	.handshake_enable, .cycle_take_enable, .stop_mode, .stop_clock_keep, .external_wait,
	.rsp, .access_req, .access_abort, .cmd_busy, .data_out, .debug_status_low);
`default_nettype wire
